/* bench/cds_exec_tb.sv */
// Self-checking bench for the complement / decrement-skip slice.
// Assumes cds_pkg is compiled first; the bench acts as register file.
module cds_exec_tb
    import cds_pkg::*;
;
timeunit 1ns;
timeprecision 1ns;

// ----------------------------------------
// Stimulus rows and signals
// ----------------------------------------
typedef struct packed {
    logic [13:0] w;
    logic [7:0] d;
    logic [13:0] nx;
    logic [7:0] nd;
    logic [7:0] acc;
    logic we;
    logic [7:0] wd;
    logic z;
    logic sk;
} cds_row_t;

// Word, read data, next word, its data, then acc/we/wdata/z/skip
localparam cds_row_t rows [12] = '{
    '{14'h0995,8'h13,14'h0000,8'h00,8'h00,1'h1,8'hEC,1'h0,1'h0},
    '{14'h097F,8'h13,14'h0000,8'h00,8'hEC,1'h0,8'h00,1'h0,1'h0},
    '{14'h0900,8'hFF,14'h0000,8'h00,8'h00,1'h0,8'h00,1'h1,1'h0},
    '{14'h0BA2,8'h00,14'h0000,8'h00,8'h00,1'h1,8'hFF,1'h1,1'h0},
    '{14'h0B10,8'h10,14'h0000,8'h00,8'h0F,1'h0,8'h00,1'h1,1'h0},
    '{14'h0981,8'h5A,14'h0000,8'h00,8'h0F,1'h1,8'hA5,1'h0,1'h0},
    '{14'h0B05,8'h02,14'h0905,8'hFF,8'h01,1'h0,8'h00,1'h0,1'h0},
    '{14'h0000,8'h00,14'h0000,8'h00,8'h00,1'h0,8'h00,1'h1,1'h0},
    '{14'h0B05,8'h01,14'h0905,8'h00,8'h00,1'h0,8'h00,1'h1,1'h1},
    '{14'h0000,8'h00,14'h0000,8'h00,8'h00,1'h0,8'h00,1'h1,1'h0},
    '{14'h0B85,8'h01,14'h0905,8'h33,8'h00,1'h1,8'h00,1'h1,1'h1},
    '{14'h0000,8'h00,14'h0000,8'h00,8'h00,1'h0,8'h00,1'h1,1'h0}
};

logic clk = 1'h0;
logic reset_n = 1'h0;
logic [13:0] insn = 14'h0000;
logic [7:0] rf_rdata = 8'h00;
logic insn_take;
logic [6:0] rf_addr;
logic [7:0] rf_wdata;
logic rf_we;
logic [7:0] acc;
logic zero_flag;
logic [1:0] phase;
logic skip_cycle;
int n_errors = 0;
int n_tests = 0;

cds_exec u_dut (
    .clk(clk),
    .reset_n(reset_n),
    .insn(insn),
    .insn_take(insn_take),
    .rf_addr(rf_addr),
    .rf_rdata(rf_rdata),
    .rf_wdata(rf_wdata),
    .rf_we(rf_we),
    .acc(acc),
    .zero_flag(zero_flag),
    .phase(phase),
    .skip_cycle(skip_cycle)
);

// 25 MHz clock
initial
begin
    forever #20 clk = ~clk;
end

// ----------------------------------------
// Tasks
// ----------------------------------------
task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        n_errors++;
    end
endtask : chk

task close_out();
    $display("checks %0d, errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask : close_out

// One word, then the following word in flight while results are checked
task go(input cds_row_t r);
    insn <= r.w;
    rf_rdata <= r.d;
    repeat (2) @(posedge clk);
    #1;
    chk({1'h0, rf_addr}, {1'h0, r.w[6:0]});
    chk({7'h00, insn_take}, 8'h00);
    repeat (2) @(posedge clk);
    insn <= r.nx;
    rf_rdata <= r.nd;
    #1;
    chk(acc, r.acc);
    chk({7'h00, rf_we}, {7'h00, r.we});
    if (r.we) chk(rf_wdata, r.wd);
    chk({7'h00, zero_flag}, {7'h00, r.z});
    chk({6'h00, phase}, 8'h00);
    chk({7'h00, insn_take}, 8'h01);
    // Skip level rises once the next word has been taken
    @(posedge clk);
    #1;
    chk({7'h00, rf_we}, 8'h00);
    chk({7'h00, skip_cycle}, {7'h00, r.sk});
    repeat (3) @(posedge clk);
endtask : go

// ----------------------------------------
// Main sequence
// ----------------------------------------
initial
begin
    repeat (4) @(posedge clk);
    #1;
    chk(acc, ACC_RESET);
    chk({7'h00, zero_flag}, 8'h00);
    chk({7'h00, rf_we}, 8'h00);
    chk({6'h00, phase}, 8'h00);
    chk({7'h00, skip_cycle}, 8'h00);
    @(posedge clk);
    reset_n <= 1'h1;
    foreach (rows[i]) go(rows[i]);
    // Reset in mid-instruction cancels the pending accumulator update
    insn <= 14'h0900;
    rf_rdata <= 8'h00;
    repeat (2) @(posedge clk);
    reset_n <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    chk(acc, ACC_RESET);
    chk({7'h00, zero_flag}, 8'h00);
    chk({6'h00, phase}, 8'h00);
    chk({7'h00, rf_we}, 8'h00);
    // Release again; the first word after reset must run in full
    @(posedge clk);
    reset_n <= 1'h1;
    go(cds_row_t'{14'h0900, 8'h0F, 14'h0000, 8'h00, 8'hF0, 1'h0, 8'h00,
        1'h0, 1'h0});
    close_out();
end

endmodule : cds_exec_tb

/* rtl/cds_alu.sv */
// Arithmetic unit for the two opcodes.
// Assumes operand is stable while phase three samples it.
module cds_alu
    import cds_pkg::*;
(
    // Operation select
    input wire logic sel_dec,
    // Data
    input wire logic [7:0] operand,
    output logic [7:0] result,
    output logic is_zero
);
    // Invert or subtract one
    always_comb
    begin
        result = sel_dec ? operand - ONE_8 : ~operand;
        is_zero = (result == ZERO_8);
    end
endmodule : cds_alu

/* rtl/cds_exec.sv */
// Decode/execute core slice for complement and decrement-skip opcodes.
// Assumes an external register file with combinational read data.
module cds_exec
    import cds_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Instruction stream
    input wire logic [13:0] insn,
    output logic insn_take,
    // Register file port
    output logic [6:0] rf_addr,
    input wire logic [7:0] rf_rdata,
    output logic [7:0] rf_wdata,
    output logic rf_we,
    // Architectural state
    output logic [7:0] acc,
    output logic zero_flag,
    output logic [1:0] phase,
    output logic skip_cycle
);
    // ----------------------------------------------------------------
    // Decode helper
    // ----------------------------------------------------------------
    function automatic logic opc_is(input logic [13:0] w,
                                    input logic [5:0] opc);
        opc_is = (w[OPC_MSB:OPC_LSB] == opc);
    endfunction : opc_is

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    cds_phase_t ph_q, ph_d;
    logic [13:0] ir_q, ir_d;
    logic [7:0] opnd_q, opnd_d;
    logic [7:0] res_q, res_d;
    logic zres_q, zres_d;
    logic nop_q, nop_d;
    logic pend_q, pend_d;
    logic [7:0] acc_q, acc_d;
    logic z_q, z_d;
    logic [7:0] wdata_q, wdata_d;
    logic we_q, we_d;
    logic [7:0] alu_res;
    logic alu_zero;
    logic is_comp, is_dec;

    assign is_comp = opc_is(ir_q, OPC_COMPLEMENT) && !nop_q;
    assign is_dec = opc_is(ir_q, OPC_DEC_SKIP) && !nop_q;

    cds_alu u_alu (
        .sel_dec(is_dec),
        .operand(opnd_q),
        .result(alu_res),
        .is_zero(alu_zero)
    );

    // Next-state for phases and datapath
    always_comb
    begin
        ph_d = cds_phase_t'(ph_q + 2'b01);
        ir_d = ir_q;
        opnd_d = opnd_q;
        res_d = res_q;
        zres_d = zres_q;
        nop_d = nop_q;
        pend_d = pend_q;
        acc_d = acc_q;
        z_d = z_q;
        wdata_d = wdata_q;
        we_d = 1'b0;
        unique case (ph_q)
            CDS_Q1:
            begin
                ir_d = insn;
                nop_d = pend_q;
                pend_d = 1'b0;
            end
            CDS_Q2:
            begin
                opnd_d = rf_rdata;
            end
            CDS_Q3:
            begin
                res_d = alu_res;
                zres_d = alu_zero;
            end
            CDS_Q4:
            begin
                if (is_comp || is_dec)
                begin
                    if (ir_q[DEST_BIT])
                    begin
                        wdata_d = res_q;
                        we_d = 1'b1;
                    end
                    else
                    begin
                        acc_d = res_q;
                    end
                end
                if (is_comp)
                    z_d = zres_q;
                if (is_dec && zres_q)
                    pend_d = 1'b1;
            end
        endcase
    end

    // Registers
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            ph_q <= CDS_Q1;
            ir_q <= '0;
            opnd_q <= ZERO_8;
            res_q <= ZERO_8;
            zres_q <= 1'b0;
            nop_q <= 1'b0;
            pend_q <= 1'b0;
            acc_q <= ACC_RESET;
            z_q <= 1'b0;
            wdata_q <= ZERO_8;
            we_q <= 1'b0;
        end
        else
        begin
            ph_q <= ph_d;
            ir_q <= ir_d;
            opnd_q <= opnd_d;
            res_q <= res_d;
            zres_q <= zres_d;
            nop_q <= nop_d;
            pend_q <= pend_d;
            acc_q <= acc_d;
            z_q <= z_d;
            wdata_q <= wdata_d;
            we_q <= we_d;
        end
    end

    // Outputs; address comes straight from the held word
    assign insn_take = (ph_q == CDS_Q1);
    assign rf_addr = ir_q[ADDR_MSB:0];
    assign rf_wdata = wdata_q;
    assign rf_we = we_q;
    assign acc = acc_q;
    assign zero_flag = z_q;
    assign phase = ph_q;
    assign skip_cycle = nop_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_PHASE_RING: assert property (
        ph_q == CDS_Q4 |=> ph_q == CDS_Q1)
        else $error("phase did not wrap");
    // write pulse only in first phase
    AST_WE_PHASE: assert property (
        rf_we |-> ph_q == CDS_Q1)
        else $error("register write outside first phase");
    AST_COMP_REG: assert property (
        ph_q == CDS_Q2 && is_comp && ir_q[DEST_BIT]
        |=> ##2 rf_we && rf_wdata == ~$past(rf_rdata, 3))
        else $error("complement write wrong");
    AST_COMP_ACC: assert property (
        ph_q == CDS_Q2 && is_comp && !ir_q[DEST_BIT]
        |=> ##2 acc == ~$past(rf_rdata, 3) && !rf_we)
        else $error("complement accumulator wrong");
    AST_DEC_REG: assert property (
        ph_q == CDS_Q2 && is_dec && ir_q[DEST_BIT]
        |=> ##2 rf_we && rf_wdata == $past(rf_rdata, 3) - ONE_8)
        else $error("decrement write wrong");
    AST_DEC_ACC: assert property (
        ph_q == CDS_Q2 && is_dec && !ir_q[DEST_BIT]
        |=> ##2 acc == $past(rf_rdata, 3) - ONE_8 && !rf_we)
        else $error("decrement accumulator wrong");
    AST_DEC_FLAGS: assert property (
        ph_q == CDS_Q4 && is_dec |=> $stable(zero_flag))
        else $error("decrement changed zero flag");
    AST_SKIP_TAKEN: assert property (
        ph_q == CDS_Q4 && is_dec && zres_q |=> ##1 skip_cycle)
        else $error("skip not taken");
    AST_NO_SKIP: assert property (
        ph_q == CDS_Q4 && (!is_dec || !zres_q) |=> ##1 !skip_cycle)
        else $error("unexpected skip");
    AST_SKIP_IDLE: assert property (
        skip_cycle |-> !rf_we && $stable(acc))
        else $error("activity in skip cycle");
    AST_COMP_Z: assert property (
        ph_q == CDS_Q4 && is_comp
        |=> zero_flag == (~$past(opnd_q) == ZERO_8))
        else $error("zero flag wrong");

    COV_COMP: cover property (ph_q == CDS_Q4 && is_comp);
    COV_DEC_NZ: cover property (ph_q == CDS_Q4 && is_dec && !zres_q);
    COV_SKIP: cover property (skip_cycle && ph_q == CDS_Q4);
    COV_SKIP_REG: cover property (ph_q == CDS_Q4 && is_dec && zres_q
        && ir_q[DEST_BIT]);
endmodule : cds_exec

/* rtl/cds_pkg.sv */
// Constants for the complement / decrement-skip execute block.
// Assumes a 14-bit instruction word and an 8-bit data path.
package cds_pkg;
    // Opcode field layout
    localparam int OPC_MSB = 13;
    localparam int OPC_LSB = 8;
    localparam int DEST_BIT = 7;
    localparam int ADDR_MSB = 6;
    localparam logic [5:0] OPC_COMPLEMENT = 6'h09;
    localparam logic [5:0] OPC_DEC_SKIP = 6'h0B;
    // Widths and reset values
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int INSN_W = 14;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] ONE_8 = 8'h01;
    localparam logic [7:0] ZERO_8 = 8'h00;
    // Phase encoding of the instruction cycle
    typedef enum logic [1:0] {
        CDS_Q1 = 2'b00,
        CDS_Q2 = 2'b01,
        CDS_Q3 = 2'b10,
        CDS_Q4 = 2'b11
    } cds_phase_t;
endpackage : cds_pkg
